// *** hw/access_guard_consts.svh ***
// Register indices, field positions and widths of the video decoder access guard.
// Assumes the includer wants plain `define names; no logic lives here.
`ifndef ACCESS_GUARD_CONSTS_SVH
`define ACCESS_GUARD_CONSTS_SVH

`define SUB_COUNT        16
`define SUB_IDX_W        4
`define DATA_W           32
`define ADDR_W           8
`define IDX_LSB          2
`define IDX_MSB          7
`define IDX_W            6
`define REG_RD_PERM      6'h10
`define REG_WR_PERM      6'h11
`define REG_LOCK         6'h12
`define REG_TRIG         6'h13
`define REG_PROT         6'h14
`define REG_FENCE_RD     6'h15
`define REG_FENCE_WR     6'h16
`define HI_HALF_BASE     16
`define RESET_WORD       32'h0000_0000

`endif

// *** hw/access_guard_pkg.sv ***
// Types shared by the video decoder access guard files.
// Assumes access_guard_consts.svh is on the include path.
`include "access_guard_consts.svh"

package access_guard_pkg;
    typedef logic [`DATA_W-1:0]    word_type;
    typedef logic [`SUB_IDX_W-1:0] sub_index_type;
    typedef logic [`IDX_W-1:0]     reg_index_type;
endpackage

// *** hw/perm_check.sv ***
// Per-transaction permission lookup with registered verdict.
// Assumes valid, index and secure come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "access_guard_consts.svh"

module perm_check
    import access_guard_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire word_type      perm,
    input  wire logic          valid,
    input  wire sub_index_type sub_requestor_index,
    input  wire logic          secure,
    output logic               allow_r,
    output logic               deny_r
);
    logic allow_nxt;
    logic deny_nxt;
    logic perm_bit;

    always_comb begin
        // Secure bit at 2n+1, non-secure at 2n
        perm_bit  = perm[{sub_requestor_index, secure}];
        allow_nxt = valid & perm_bit;
        deny_nxt  = valid & ~perm_bit;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            allow_r <= 1'b0;
            deny_r  <= 1'b0;
        end else begin
            allow_r <= allow_nxt;
            deny_r  <= deny_nxt;
        end
    end
endmodule // perm_check

`default_nettype wire

// *** hw/video_decoder_access_guard.sv ***
// Access guard for the sixteen video decoder sub-requestors, with APB register slave.
// Assumes APB and requestor strobes are synchronous to clk; secure flags come from the range decoder.
`timescale 1ns/100ps
`default_nettype none
`include "access_guard_consts.svh"

// Operation
// - Write permission bit 2n+1 allows secure-region writes for sub-requestor n.
// - Write permission bit 2n allows non-secure-region writes for sub-requestor n.
// - Lock register bits 31..16 let the bus change each write permission pair.
// - Lock register bits 15..0 let the bus change each read permission pair.
// - Lock bit 1 accepts bus changes; 0 keeps the permission bits unchanged by bus writes (a fence trip still loads them).
// - Lock register holds two bits per sub-requestor: read and write.
// - Fence trips on a read at the chosen level by a selected source.
// - Trigger register holds one select and one type bit per sub-requestor.
// - Trigger bit 16+n: 1 trips on secure reads, 0 on non-secure reads.
// - Trigger bit n marks sub-requestor n as a fence source.
// - Read permissions use the same layout: secure 2n+1, non-secure 2n.
// - On a trip, post-trip values load into live permissions of protected requestors.
module video_decoder_access_guard
    import access_guard_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [`ADDR_W-1:0] paddr,
    input  wire word_type          pwdata,
    output word_type               prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rd_valid,
    input  wire sub_index_type     rd_sub_requestor_index,
    input  wire logic              rd_secure,
    input  wire logic              wr_valid,
    input  wire sub_index_type     wr_sub_requestor_index,
    input  wire logic              wr_secure,
    output logic                   rd_allow,
    output logic                   rd_block,
    output logic                   wr_allow,
    output logic                   wr_block,
    output logic                   fence_trip
);
    word_type      decoder_read_permissions_r;
    word_type      decoder_read_permissions_nxt;
    word_type      decoder_write_permissions_r;
    word_type      decoder_write_permissions_nxt;
    word_type      permission_update_lock_r;
    word_type      permission_update_lock_nxt;
    word_type      fence_trigger_control_r;
    word_type      fence_trigger_control_nxt;
    word_type      fence_protect_select_r;
    word_type      fence_protect_select_nxt;
    word_type      fence_read_values_r;
    word_type      fence_read_values_nxt;
    word_type      fence_write_values_r;
    word_type      fence_write_values_nxt;
    word_type      prdata_r;
    word_type      prdata_nxt;
    logic          pready_r;
    logic          pready_nxt;
    logic          pslverr_r;
    logic          pslverr_nxt;
    logic          fence_trip_r;
    logic          fence_trip_nxt;

    word_type      rd_lock_mask;
    word_type      wr_lock_mask;
    word_type      rd_prot_mask;
    word_type      wr_prot_mask;
    logic [`SUB_COUNT-1:0] trig_hit;
    logic          trip_now;
    logic          setup_phase;
    logic          bus_write;
    logic          hit;
    reg_index_type reg_index;

    assign setup_phase = psel & ~penable;
    assign reg_index   = paddr[`IDX_MSB:`IDX_LSB];
    assign bus_write   = setup_phase & pwrite;

    genvar n;
    generate
        for (n = 0; n < `SUB_COUNT; n = n + 1) begin : g_sub
            // Two lock bits per requestor, each spanning its permission pair
            assign rd_lock_mask[2*n+1:2*n] = {2{permission_update_lock_r[n]}};
            assign wr_lock_mask[2*n+1:2*n] = {2{permission_update_lock_r[`HI_HALF_BASE+n]}};
            assign rd_prot_mask[2*n+1:2*n] = {2{fence_protect_select_r[n]}};
            assign wr_prot_mask[2*n+1:2*n] = {2{fence_protect_select_r[`HI_HALF_BASE+n]}};
            assign trig_hit[n] = rd_valid
                               & (rd_sub_requestor_index == sub_index_type'(n))
                               & fence_trigger_control_r[n]
                               & (fence_trigger_control_r[`HI_HALF_BASE+n] == rd_secure);
        end
    endgenerate

    assign trip_now = |trig_hit;

    always_comb begin
        decoder_read_permissions_nxt  = decoder_read_permissions_r;
        decoder_write_permissions_nxt = decoder_write_permissions_r;
        permission_update_lock_nxt    = permission_update_lock_r;
        fence_trigger_control_nxt     = fence_trigger_control_r;
        fence_protect_select_nxt      = fence_protect_select_r;
        fence_read_values_nxt         = fence_read_values_r;
        fence_write_values_nxt        = fence_write_values_r;
        if (bus_write) begin
            case (reg_index)
                `REG_RD_PERM: begin
                    decoder_read_permissions_nxt = (decoder_read_permissions_r & ~rd_lock_mask)
                                                 | (pwdata & rd_lock_mask);
                end
                `REG_WR_PERM: begin
                    decoder_write_permissions_nxt = (decoder_write_permissions_r & ~wr_lock_mask)
                                                  | (pwdata & wr_lock_mask);
                end
                `REG_LOCK:     permission_update_lock_nxt = pwdata;
                `REG_TRIG:     fence_trigger_control_nxt  = pwdata;
                `REG_PROT:     fence_protect_select_nxt   = pwdata;
                `REG_FENCE_RD: fence_read_values_nxt      = pwdata;
                `REG_FENCE_WR: fence_write_values_nxt     = pwdata;
                default: begin
                end
            endcase
        end
        // A trip overrides a bus write in the same cycle so software cannot race the fence
        if (trip_now) begin
            decoder_read_permissions_nxt  = (decoder_read_permissions_nxt & ~rd_prot_mask)
                                          | (fence_read_values_r & rd_prot_mask);
            decoder_write_permissions_nxt = (decoder_write_permissions_nxt & ~wr_prot_mask)
                                          | (fence_write_values_r & wr_prot_mask);
        end
        fence_trip_nxt = trip_now;
    end

    always_comb begin
        hit = 1'b1;
        case (reg_index)
            `REG_RD_PERM:  prdata_nxt = decoder_read_permissions_r;
            `REG_WR_PERM:  prdata_nxt = decoder_write_permissions_r;
            `REG_LOCK:     prdata_nxt = permission_update_lock_r;
            `REG_TRIG:     prdata_nxt = fence_trigger_control_r;
            `REG_PROT:     prdata_nxt = fence_protect_select_r;
            `REG_FENCE_RD: prdata_nxt = fence_read_values_r;
            `REG_FENCE_WR: prdata_nxt = fence_write_values_r;
            default: begin
                prdata_nxt = `RESET_WORD;
                hit        = 1'b0;
            end
        endcase
        if (!setup_phase || pwrite) begin
            prdata_nxt = `RESET_WORD;
        end
        // Zero-wait access: verdict prepared in setup, shown in access phase
        pready_nxt  = setup_phase;
        pslverr_nxt = setup_phase & ~hit;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            decoder_read_permissions_r  <= `RESET_WORD;
            decoder_write_permissions_r <= `RESET_WORD;
            permission_update_lock_r    <= `RESET_WORD;
            fence_trigger_control_r     <= `RESET_WORD;
            fence_protect_select_r      <= `RESET_WORD;
            fence_read_values_r         <= `RESET_WORD;
            fence_write_values_r        <= `RESET_WORD;
            prdata_r                    <= `RESET_WORD;
            pready_r                    <= 1'b0;
            pslverr_r                   <= 1'b0;
            fence_trip_r                <= 1'b0;
        end else begin
            decoder_read_permissions_r  <= decoder_read_permissions_nxt;
            decoder_write_permissions_r <= decoder_write_permissions_nxt;
            permission_update_lock_r    <= permission_update_lock_nxt;
            fence_trigger_control_r     <= fence_trigger_control_nxt;
            fence_protect_select_r      <= fence_protect_select_nxt;
            fence_read_values_r         <= fence_read_values_nxt;
            fence_write_values_r        <= fence_write_values_nxt;
            prdata_r                    <= prdata_nxt;
            pready_r                    <= pready_nxt;
            pslverr_r                   <= pslverr_nxt;
            fence_trip_r                <= fence_trip_nxt;
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign fence_trip = fence_trip_r;

    // Checks use permissions as they stand before any trip in the same cycle
    perm_check u_read_check (
        .clk                 (clk),
        .rst                 (rst),
        .perm                (decoder_read_permissions_r),
        .valid               (rd_valid),
        .sub_requestor_index (rd_sub_requestor_index),
        .secure              (rd_secure),
        .allow_r             (rd_allow),
        .deny_r              (rd_block)
    );

    perm_check u_write_check (
        .clk                 (clk),
        .rst                 (rst),
        .perm                (decoder_write_permissions_r),
        .valid               (wr_valid),
        .sub_requestor_index (wr_sub_requestor_index),
        .secure              (wr_secure),
        .allow_r             (wr_allow),
        .deny_r              (wr_block)
    );
endmodule // video_decoder_access_guard

`default_nettype wire

// *** test/guard_monitor.sv ***
// Port-level checks for the video decoder access guard.
// Assumes it is bound to the guard and shares its clk and rst.
`timescale 1ns/100ps
`default_nettype none
module guard_monitor
    import access_guard_pkg::*;
(
    input wire logic     clk,
    input wire logic     rst,
    input wire logic     psel,
    input wire logic     penable,
    input wire word_type prdata,
    input wire logic     pready,
    input wire logic     pslverr,
    input wire logic     rd_valid,
    input wire logic     wr_valid,
    input wire logic     rd_allow,
    input wire logic     rd_block,
    input wire logic     wr_allow,
    input wire logic     wr_block,
    input wire logic     fence_trip
);
    default clocking mon_clk @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single pulse after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside access");
    a_rd_single_verdict: assert property (rd_valid |=> rd_allow != rd_block)
        else $error("read verdict missing or doubled");
    a_rd_no_spurious: assert property (!rd_valid |=> !rd_allow && !rd_block)
        else $error("read verdict without request");
    a_wr_single_verdict: assert property (wr_valid |=> wr_allow != wr_block)
        else $error("write verdict missing or doubled");
    a_wr_no_spurious: assert property (!wr_valid |=> !(wr_allow || wr_block))
        else $error("write verdict without request");
    a_trip_after_read: assert property (fence_trip |-> $past(rd_valid))
        else $error("fence trip without read");
endmodule // guard_monitor

bind video_decoder_access_guard guard_monitor u_mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .wr_valid(wr_valid),
    .rd_allow(rd_allow), .rd_block(rd_block), .wr_allow(wr_allow), .wr_block(wr_block), .fence_trip(fence_trip));
`default_nettype wire

// *** test/requestor_model.sv ***
// Behavioural decoder sub-requestors: one read port and one write port.
// Assumes the bench calls issue; requests last one cycle.
`timescale 1ns/100ps
`default_nettype none
module requestor_model
    import access_guard_pkg::*;
(
    input  wire logic     clk,
    output sub_index_type rd_sub_requestor_index,
    output sub_index_type wr_sub_requestor_index,
    output logic          rd_valid = 1'h0,
    output logic          rd_secure = 1'h0,
    output logic          wr_valid = 1'h0,
    output logic          wr_secure = 1'h0
);
    initial rd_sub_requestor_index = 4'h0;
    initial wr_sub_requestor_index = 4'h0;
    // Qualifiers are scrambled after release so a stale index cannot pass for a request
    task automatic issue(input logic wr, input sub_index_type n, input logic sec);
        @(negedge clk);
        rd_valid = !wr;
        wr_valid = wr;
        rd_sub_requestor_index = n;
        wr_sub_requestor_index = n;
        rd_secure = sec;
        wr_secure = sec;
        @(negedge clk);
        rd_valid = 1'h0;
        wr_valid = 1'h0;
        rd_sub_requestor_index = ~n;
        wr_sub_requestor_index = ~n;
        rd_secure = !sec;
        wr_secure = !sec;
    endtask
endmodule // requestor_model
`default_nettype wire

// *** test/tb.sv ***
// Random self-checking bench comparing the guard with a register-level model.
// Assumes the guard, checker and requestor model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "access_guard_consts.svh"
module tb
    import access_guard_pkg::*;
;
    logic          clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]    paddr = 8'h00;
    word_type      pwdata = 32'h0, prdata;
    logic          pready, pslverr, rd_valid, rd_secure, wr_valid, wr_secure;
    logic          rd_allow, rd_block, wr_allow, wr_block, fence_trip;
    sub_index_type rd_sub_requestor_index, wr_sub_requestor_index;
    word_type      regs [7] = '{default: 32'h0};
    int            miscompares = 0, n_tests = 0, cycles = 0;
    always #5 clk = ~clk;
    video_decoder_access_guard DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rd_valid(rd_valid), .rd_sub_requestor_index(rd_sub_requestor_index), .rd_secure(rd_secure),
        .wr_valid(wr_valid), .wr_sub_requestor_index(wr_sub_requestor_index), .wr_secure(wr_secure),
        .rd_allow(rd_allow), .rd_block(rd_block), .wr_allow(wr_allow), .wr_block(wr_block), .fence_trip(fence_trip));
    requestor_model rq (.clk(clk), .rd_valid(rd_valid), .rd_sub_requestor_index(rd_sub_requestor_index),
        .rd_secure(rd_secure), .wr_valid(wr_valid), .wr_sub_requestor_index(wr_sub_requestor_index),
        .wr_secure(wr_secure));
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input word_type got, input word_type exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Sixteen per-requestor bits widened to their permission pairs
    function automatic word_type pairs(input word_type l);
        for (int m = 0; m < 16; m++) pairs[2*m+:2] = {2{l[m]}};
    endfunction
    task automatic apb(input logic wr, input logic [5:0] idx, input word_type d);
        @(negedge clk);
        psel = 1'h1;
        pwrite = wr;
        paddr = {idx, 2'($urandom)};
        pwdata = d;
        @(negedge clk);
        penable = 1'h1;
        // Access-phase outputs stand from the last rising edge; sample them away from any edge
        check(pready, 1, "pready");
        check(pslverr, idx == 6'h17, "pslverr");
        check(prdata, (wr || idx == 6'h17) ? 32'h0 : regs[idx-6'h10], "prdata");
        @(posedge clk);
        @(negedge clk);
        psel = 1'h0;
        penable = 1'h0;
        if (wr && idx == `REG_RD_PERM) regs[0] = regs[0] & ~pairs(regs[2]) | d & pairs(regs[2]);
        else if (wr && idx == `REG_WR_PERM) regs[1] = regs[1] & ~pairs(regs[2] >> 16) | d & pairs(regs[2] >> 16);
        else if (wr && idx != 6'h17) regs[idx-6'h10] = d;
    endtask
    task automatic request(input logic wr, input sub_index_type n, input logic sec);
        logic ok, trip;
        ok = wr ? regs[1][2*n+sec] : regs[0][2*n+sec];
        trip = !wr && regs[3][n] && regs[3][16+n] == sec;
        rq.issue(wr, n, sec);
        check(wr ? wr_allow : rd_allow, ok, "allow");
        check(wr ? wr_block : rd_block, !ok, "block");
        check(fence_trip, trip, "fence_trip");
        if (trip) begin
            regs[0] = regs[0] & ~pairs(regs[4]) | regs[5] & pairs(regs[4]);
            regs[1] = regs[1] & ~pairs(regs[4] >> 16) | regs[6] & pairs(regs[4] >> 16);
        end
    endtask
    initial begin
        int op;
        void'($urandom(23816));
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        for (int i = 0; i < 8; i++) apb(1'h0, 6'h10 + 6'(i), 32'h0);
        for (int i = 0; i < 700; i++) begin
            op = $urandom_range(3);
            if (op < 2) apb(op == 0, 6'h10 + 6'($urandom_range(7)), $urandom);
            else request(1'($urandom), 4'($urandom), 1'($urandom));
        end
        finish_test();
    end
endmodule // tb
`default_nettype wire
